// ---- pkg/ufi_pkg.sv ----
// Constants for the USB function interrupt mask and clear block
package ufi_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_EP0_GENERAL_IRQ_MASK     = 32'hFFFF_FE18;
  localparam logic [31:0] IDX_BULK_IN_INTR_EP_IRQ_MASK = 32'hFFFF_FE19;
  localparam logic [31:0] IDX_BULK_OUT_IRQ_MASK        = 32'hFFFF_FE1A;
  localparam logic [31:0] IDX_SET_INTERFACE_IRQ_MASK   = 32'h0FFF_FE1B;
  localparam logic [31:0] IDX_BUS_EVENT_IRQ_CLEAR      = 32'hFFFF_FE1E;
  localparam logic [31:0] IDX_EP0_GENERAL_IRQ_CLEAR    = 32'hFFFF_FE1F;

  // ----------------------------------------------------------------
  // Reset values and implemented bits
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_RST_VAL          = 8'h00;
  localparam logic [7:0] CLEAR_RST_VAL         = 8'hFF;
  localparam logic [7:0] EP0_MASK_BITS         = 8'h7F;
  localparam logic [7:0] BULK_IN_MASK_BITS     = 8'hF3;
  localparam logic [7:0] BULK_OUT_MASK_BITS    = 8'hFF;
  localparam logic [7:0] SETIF_MASK_BITS       = 8'h20;
  localparam logic [7:0] BUS_EVENT_CLR_FIXED   = 8'h20;
  localparam logic [7:0] EP0_GENERAL_CLR_FIXED = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EP0_IN_MASK_POS      = 6;
  localparam int EP0_IN_DATA_MASK_POS = 5;
  localparam int EP0_OUT_DATA_POS     = 4;
  localparam int SUCCESS_MASK_POS     = 3;
  localparam int STG_MASK_POS         = 2;
  localparam int PROTECT_MASK_POS     = 1;
  localparam int CPU_DECODE_MASK_POS  = 0;
  localparam int BULK_IN2_TOKEN_POS   = 7;
  localparam int BULK_IN2_DONE_POS    = 6;
  localparam int BULK_IN1_TOKEN_POS   = 5;
  localparam int BULK_IN1_DONE_POS    = 4;
  localparam int INTR_EP2_DATA_POS    = 1;
  localparam int INTR_EP1_DATA_POS    = 0;
  localparam int BULK_OUT_EP_FIELDS   = 4;
  localparam int BULK_OUT_DONE_OFS    = 0;
  localparam int BULK_OUT_NAK_OFS     = 1;
  localparam int BULK_OUT_ZLEN_OFS    = 2;
  localparam int BULK_OUT_FULL_OFS    = 3;
  localparam int SET_INTERFACE_POS    = 5;
  localparam int BUS_RESET_CLR_POS    = 7;
  localparam int RESUME_SUSP_CLR_POS  = 6;

endpackage

// ---- rtl/ufi_clear_reg.sv ----
// Write-only clear register that turns written zeros into clear pulses
`timescale 1ns/1ps
`default_nettype none
module ufi_clear_reg #(
  parameter logic [7:0] FIXED_ONE = 8'h00
) (
  input  wire  logic       core_clk,
  input  wire  logic       reset,
  input  wire  logic       wr_stb,
  input  wire  logic [7:0] wr_data,
  output logic [7:0]       clear_pulse
);
  import ufi_pkg::*;

  logic [7:0] pulse_r;
  logic [7:0] pulse_nxt;

  // Zero bits become clear requests; ones and fixed bits do nothing
  assign pulse_nxt   = wr_stb ? (~wr_data & ~FIXED_ONE) : ~CLEAR_RST_VAL;
  assign clear_pulse = pulse_r;

  // Pulse lasts one cycle, so the register reads back all ones again
  always_ff @(posedge core_clk)
  begin
    if (reset)
      pulse_r <= ~CLEAR_RST_VAL;
    else
      pulse_r <= pulse_nxt;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_clr_one_cycle;
    (pulse_r != 8'h00) && !wr_stb |=> (pulse_r == 8'h00);
  endproperty
  a_clr_one_cycle: assert property (p_clr_one_cycle)
    else $error("clear pulse lasted more than one cycle");

  property p_clr_fixed;
    (pulse_r & FIXED_ONE) == 8'h00;
  endproperty
  a_clr_fixed: assert property (p_clr_fixed)
    else $error("fixed clear bit produced a pulse");

endmodule
`default_nettype wire

// ---- rtl/ufi_irq_mask_clear.sv ----
// Interrupt mask and clear registers with three interrupt request lines
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ufi_irq_mask_clear (
  input  wire  logic        core_clk,
  input  wire  logic        reset,
  input  wire  logic [31:0] avs_address,
  input  wire  logic        avs_read,
  input  wire  logic        avs_write,
  input  wire  logic [31:0] avs_writedata,
  input  wire  logic [3:0]  avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  input  wire  logic        bus_event_irq_req,
  input  wire  logic [7:0]  ep0_general_status,
  input  wire  logic [7:0]  bulk_in_intr_ep_status,
  input  wire  logic [7:0]  bulk_out_status,
  input  wire  logic [7:0]  set_interface_status,
  input  wire  logic [1:0]  bulk_in_supported,
  input  wire  logic [1:0]  intr_ep_supported,
  input  wire  logic [1:0]  bulk_out_supported,
  input  wire  logic        set_interface_supported,
  output logic [7:0]        bus_event_clear_pulse,
  output logic [7:0]        ep0_general_clear_pulse,
  output logic              general_irq_line,
  output logic              endpoint_irq_line,
  output logic              setif_irq_line
);
  import ufi_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  ep0_mask_r;
  logic [7:0]  bulk_in_mask_r;
  logic [7:0]  bulk_out_mask_r;
  logic [7:0]  setif_mask_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        gen_line_r;
  logic        ep_line_r;
  logic        setif_line_r;
  logic        gen_line_nxt;
  logic        ep_line_nxt;
  logic        setif_line_nxt;
  logic        req;
  logic        wr_en;
  logic        hit_ep0_mask;
  logic        hit_bulk_in_mask;
  logic        hit_bulk_out_mask;
  logic        hit_setif_mask;
  logic        hit_bus_clr;
  logic        hit_ep0_clr;
  logic        hit_any;
  logic [7:0]  wbyte;
  logic [7:0]  bulk_in_src_en;
  logic [7:0]  bulk_out_src_en;
  logic [7:0]  ep0_pending;
  logic [7:0]  bulk_in_pending;
  logic [7:0]  bulk_out_pending;
  logic [7:0]  setif_pending;
  logic [7:0]  rd_byte;

  // ----------------------------------------------------------------
  // Avalon-MM slave handshake
  // ----------------------------------------------------------------
  // Every access waits exactly one cycle, then completes
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_en           = avs_write & ack_r & avs_byteenable[0];
  assign wbyte           = avs_writedata[7:0];
  assign avs_readdata    = rdata_r;

  // Address decode; unmapped words read zero and ignore writes
  assign hit_ep0_mask      = (avs_address == IDX_EP0_GENERAL_IRQ_MASK);
  assign hit_bulk_in_mask  = (avs_address == IDX_BULK_IN_INTR_EP_IRQ_MASK);
  assign hit_bulk_out_mask = (avs_address == IDX_BULK_OUT_IRQ_MASK);
  assign hit_setif_mask    = (avs_address == IDX_SET_INTERFACE_IRQ_MASK);
  assign hit_bus_clr       = (avs_address == IDX_BUS_EVENT_IRQ_CLEAR);
  assign hit_ep0_clr       = (avs_address == IDX_EP0_GENERAL_IRQ_CLEAR);
  assign hit_any           = hit_ep0_mask | hit_bulk_in_mask | hit_bulk_out_mask
                           | hit_setif_mask | hit_bus_clr | hit_ep0_clr;

  // Read mux; clear registers always read all ones
  assign rd_byte = hit_ep0_mask      ? ep0_mask_r      :
                   hit_bulk_in_mask  ? bulk_in_mask_r  :
                   hit_bulk_out_mask ? bulk_out_mask_r :
                   hit_setif_mask    ? setif_mask_r    :
                   (hit_bus_clr | hit_ep0_clr) ? CLEAR_RST_VAL : 8'h00;
  assign rdata_nxt = (avs_read & hit_any) ? {24'h00_0000, rd_byte} : 32'h0000_0000;

  // Handshake state and read data capture
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r   <= req & ~ack_r;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  // Writes keep only implemented bits; unused bits stay zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ep0_mask_r      <= MASK_RST_VAL;
      bulk_in_mask_r  <= MASK_RST_VAL;
      bulk_out_mask_r <= MASK_RST_VAL;
      setif_mask_r    <= MASK_RST_VAL;
    end
    else if (wr_en)
    begin
      if (hit_ep0_mask)
        ep0_mask_r <= wbyte & EP0_MASK_BITS;
      if (hit_bulk_in_mask)
        bulk_in_mask_r <= wbyte & BULK_IN_MASK_BITS;
      if (hit_bulk_out_mask)
        bulk_out_mask_r <= wbyte & BULK_OUT_MASK_BITS;
      if (hit_setif_mask)
        setif_mask_r <= wbyte & SETIF_MASK_BITS;
    end
  end

  // ----------------------------------------------------------------
  // Clear registers
  // ----------------------------------------------------------------
  // Bus-event sources: reset, resume/suspend, short, DMA end, requests, halt
  ufi_clear_reg #(
    .FIXED_ONE (BUS_EVENT_CLR_FIXED)
  ) u_bus_event_clr (
    .core_clk    (core_clk),
    .reset       (reset),
    .wr_stb      (wr_en & hit_bus_clr),
    .wr_data     (wbyte),
    .clear_pulse (bus_event_clear_pulse)
  );

  // EP0 and general sources
  ufi_clear_reg #(
    .FIXED_ONE (EP0_GENERAL_CLR_FIXED)
  ) u_ep0_general_clr (
    .core_clk    (core_clk),
    .reset       (reset),
    .wr_stb      (wr_en & hit_ep0_clr),
    .wr_data     (wbyte),
    .clear_pulse (ep0_general_clear_pulse)
  );

  // ----------------------------------------------------------------
  // Endpoint support gating
  // ----------------------------------------------------------------
  // Sources of unsupported endpoints never reach a line, so masks are moot
  assign bulk_in_src_en[BULK_IN2_TOKEN_POS] = bulk_in_supported[1];
  assign bulk_in_src_en[BULK_IN2_DONE_POS]  = bulk_in_supported[1];
  assign bulk_in_src_en[BULK_IN1_TOKEN_POS] = bulk_in_supported[0];
  assign bulk_in_src_en[BULK_IN1_DONE_POS]  = bulk_in_supported[0];
  assign bulk_in_src_en[3:2]                = 2'b00;
  assign bulk_in_src_en[INTR_EP2_DATA_POS]  = intr_ep_supported[1];
  assign bulk_in_src_en[INTR_EP1_DATA_POS]  = intr_ep_supported[0];

  // Four bulk-out fields per endpoint, endpoint 1 in the low nibble
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_bo_en
      assign bulk_out_src_en[gi] = bulk_out_supported[gi / BULK_OUT_EP_FIELDS];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt request lines
  // ----------------------------------------------------------------
  // Masking gates only the lines; status inputs are never touched
  assign ep0_pending      = ep0_general_status & ~ep0_mask_r & EP0_MASK_BITS;
  assign bulk_in_pending  = bulk_in_intr_ep_status & ~bulk_in_mask_r & bulk_in_src_en;
  assign bulk_out_pending = bulk_out_status & ~bulk_out_mask_r & bulk_out_src_en;
  assign setif_pending    = set_interface_status & ~setif_mask_r & SETIF_MASK_BITS
                          & {8{set_interface_supported}};

  assign gen_line_nxt   = (|ep0_pending) | bus_event_irq_req;
  assign ep_line_nxt    = (|bulk_in_pending) | (|bulk_out_pending);
  assign setif_line_nxt = |setif_pending;

  assign general_irq_line  = gen_line_r;
  assign endpoint_irq_line = ep_line_r;
  assign setif_irq_line    = setif_line_r;

  // Registered lines, one cycle behind status and mask
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      gen_line_r   <= 1'b0;
      ep_line_r    <= 1'b0;
      setif_line_r <= 1'b0;
    end
    else
    begin
      gen_line_r   <= gen_line_nxt;
      ep_line_r    <= ep_line_nxt;
      setif_line_r <= setif_line_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_ep0_mask_write;
    avs_write && !avs_waitrequest && avs_byteenable[0] && hit_ep0_mask
      |=> ep0_mask_r == ($past(avs_writedata[7:0]) & 8'h7F);
  endproperty
  a_ep0_mask_write: assert property (p_ep0_mask_write)
    else $error("EP0 mask register did not take the written byte");

  property p_gen_masked;
    ((ep0_general_status & ~ep0_mask_r & 8'h7F) == 8'h00) && !bus_event_irq_req
      |=> !general_irq_line;
  endproperty
  a_gen_masked: assert property (p_gen_masked)
    else $error("general line high with every source masked");

  property p_gen_raise;
    (ep0_general_status[3] && !ep0_mask_r[3]) |=> general_irq_line;
  endproperty
  a_gen_raise: assert property (p_gen_raise)
    else $error("general line low with unmasked success source");

  // Fixed-zero mask bits must read back as zero over the bus
  property p_bulk_in_fixed;
    avs_read && !avs_waitrequest && (hit_bulk_in_mask || hit_setif_mask)
      |-> avs_readdata[3:2] == 2'b00 && (!hit_setif_mask || avs_readdata[7:6] == 2'b00);
  endproperty
  a_bulk_in_fixed: assert property (p_bulk_in_fixed)
    else $error("fixed mask bits read nonzero");

  property p_ep_unsupported;
    (bulk_in_supported == 2'b00 && intr_ep_supported == 2'b00
      && bulk_out_supported == 2'b00) [*2] |-> !endpoint_irq_line;
  endproperty
  a_ep_unsupported: assert property (p_ep_unsupported)
    else $error("endpoint line high with no supported endpoint");

  property p_bulk_out_masked;
    (bulk_out_mask_r == 8'hFF && bulk_in_mask_r == 8'hF3) |=> !endpoint_irq_line;
  endproperty
  a_bulk_out_masked: assert property (p_bulk_out_masked)
    else $error("endpoint line high with all masks set");

  property p_setif;
    setif_mask_r[5] || !set_interface_supported |=> !setif_irq_line;
  endproperty
  a_setif: assert property (p_setif)
    else $error("set-interface line high while masked or unsupported");

  property p_clear_read;
    avs_read && (hit_bus_clr || hit_ep0_clr) && avs_waitrequest
      ##1 !avs_waitrequest |-> avs_readdata == 32'h0000_00FF;
  endproperty
  a_clear_read: assert property (p_clear_read)
    else $error("clear register did not read all ones");

  property p_clear_pulse;
    avs_write && !avs_waitrequest && avs_byteenable[0] && hit_ep0_clr
      |=> ep0_general_clear_pulse == (~$past(avs_writedata[7:0]) & 8'h7F)
      ##1 ep0_general_clear_pulse == 8'h00;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("EP0 clear pulse wrong or too long");

  property p_bus_reset_clear;
    avs_write && !avs_waitrequest && avs_byteenable[0] && hit_bus_clr
      && !avs_writedata[7] |=> bus_event_clear_pulse[7];
  endproperty
  a_bus_reset_clear: assert property (p_bus_reset_clear)
    else $error("bus reset clear pulse missing");

  property p_wait_bound;
    req |-> ##[0:1] !avs_waitrequest;
  endproperty
  a_wait_bound: assert property (p_wait_bound)
    else $error("access not answered within one wait cycle");

  // An unmasked, supported endpoint source must raise the endpoint line
  property p_ep_raise;
    bulk_out_status[0] && !bulk_out_mask_r[0] && bulk_out_supported[0] |=> endpoint_irq_line;
  endproperty
  a_ep_raise: assert property (p_ep_raise)
    else $error("endpoint line low with unmasked reception source");

  // An unmasked, supported set-interface source must raise its line
  property p_setif_raise;
    set_interface_status[5] && !setif_mask_r[5] && set_interface_supported
      |=> setif_irq_line;
  endproperty
  a_setif_raise: assert property (p_setif_raise)
    else $error("set-interface line low with unmasked source");

  // A mask register changes only through a completed write
  property p_mask_hold;
    !(avs_write && !avs_waitrequest && hit_bulk_out_mask) |=> $stable(bulk_out_mask_r);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("bulk-out mask changed without a write");

  // Ones written to a clear register give no pulse
  property p_clear_ones;
    avs_write && !avs_waitrequest && avs_byteenable[0] && hit_bus_clr
      && avs_writedata[7:0] == 8'hFF |=> bus_event_clear_pulse == 8'h00;
  endproperty
  a_clear_ones: assert property (p_clear_ones)
    else $error("clear pulse after writing all ones");

  c_mask_write: cover property (avs_write && !avs_waitrequest && hit_bulk_out_mask);
  c_clear_write: cover property (avs_write && !avs_waitrequest && hit_bus_clr);
  c_ep_line: cover property (!endpoint_irq_line ##1 endpoint_irq_line);
  c_setif_line: cover property (setif_irq_line);

endmodule
`default_nettype wire

// ---- verification/ufi_irq_mask_clear_test.sv ----
// Self-checking bench for the USB function interrupt mask and clear block
`timescale 1ns/1ps
`default_nettype none
module ufi_irq_mask_clear_test;
  import ufi_pkg::*;

  // ------------------------------------------------------------
  // Signals and bookkeeping
  // ------------------------------------------------------------
  logic        core_clk;
  logic        reset;
  logic [31:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        bus_event_irq_req;
  logic [7:0]  ep0_general_status;
  logic [7:0]  bulk_in_intr_ep_status;
  logic [7:0]  bulk_out_status;
  logic [7:0]  set_interface_status;
  logic [5:0]  sup_v;
  logic        set_interface_supported;
  logic [7:0]  bus_event_clear_pulse;
  logic [7:0]  ep0_general_clear_pulse;
  logic        general_irq_line;
  logic        endpoint_irq_line;
  logic        setif_irq_line;
  logic        wait_seen;
  logic [7:0]  d;
  logic [31:0] ca;
  logic [15:0] ex;
  logic [31:0] rd_q[$];
  logic [15:0] pulse_q[$];
  int          mismatches;
  int          n_compared;
  int          cycles = 0;
  logic [31:0] midx[4] = '{IDX_EP0_GENERAL_IRQ_MASK, IDX_BULK_IN_INTR_EP_IRQ_MASK,
                           IDX_BULK_OUT_IRQ_MASK, IDX_SET_INTERFACE_IRQ_MASK};
  logic [7:0]  mbits[4] = '{EP0_MASK_BITS, BULK_IN_MASK_BITS, BULK_OUT_MASK_BITS,
                            SETIF_MASK_BITS};

  ufi_irq_mask_clear ufi_irq_mask_clear_inst (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bus_event_irq_req(bus_event_irq_req), .ep0_general_status(ep0_general_status),
    .bulk_in_intr_ep_status(bulk_in_intr_ep_status), .bulk_out_status(bulk_out_status),
    .set_interface_status(set_interface_status), .bulk_in_supported(sup_v[1:0]),
    .intr_ep_supported(sup_v[3:2]), .bulk_out_supported(sup_v[5:4]),
    .set_interface_supported(set_interface_supported),
    .bus_event_clear_pulse(bus_event_clear_pulse),
    .ep0_general_clear_pulse(ep0_general_clear_pulse), .general_irq_line(general_irq_line),
    .endpoint_irq_line(endpoint_irq_line), .setif_irq_line(setif_irq_line));

  // ------------------------------------------------------------
  // Clock, comparison and bus tasks
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest was seen low at a falling edge
  task automatic bus_xfer(input logic rd, input logic [31:0] a, input logic [7:0] dat,
                          input logic [3:0] be);
    avs_read       <= rd;
    avs_write      <= ~rd;
    avs_address    <= a;
    avs_writedata  <= {24'h00_0000, dat};
    avs_byteenable <= be;
    @(posedge core_clk);
    while (wait_seen !== 1'b0)
      @(posedge core_clk);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic bus_write(input logic [31:0] a, input logic [7:0] dat);
    bus_xfer(1'b0, a, dat, 4'h1);
  endtask

  task automatic bus_read(input logic [31:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus_xfer(1'b1, a, 8'h00, 4'h1);
  endtask

  // Lines are registered: let two edges pass, then look
  task automatic check_lines(input logic [2:0] exp);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("irq lines", {29'h0000_0000, exp},
        {29'h0000_0000, general_irq_line, endpoint_irq_line, setif_irq_line});
    @(posedge core_clk);
  endtask

  // Support bit that governs one endpoint status bit (16 = in/out pair)
  function automatic int sup_idx(input int b);
    if (b >= 12) return 5;
    if (b >= 8) return 4;
    if (b >= 6) return 1;
    if (b >= 4) return 0;
    return (b == 1) ? 3 : 2;
  endfunction

  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Output watcher: read data and clear pulses against notes
  // ------------------------------------------------------------
  always @(negedge core_clk)
  begin
    wait_seen = avs_waitrequest;
    if (!reset && avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk("readdata", (rd_q.size() > 0) ? rd_q.pop_front() : 32'hxxxx_xxxx,
          avs_readdata);
    if (!reset && (bus_event_clear_pulse | ep0_general_clear_pulse) !== 8'h00)
      chk("clear pulses",
          {16'h0000, (pulse_q.size() > 0) ? pulse_q.pop_front() : 16'hxxxx},
          {16'h0000, bus_event_clear_pulse, ep0_general_clear_pulse});
  end

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    mismatches = 0;
    n_compared = 0;
    reset = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {bus_event_irq_req, ep0_general_status, bulk_in_intr_ep_status} = '0;
    {bulk_out_status, set_interface_status} = '0;
    sup_v = 6'h3F;
    set_interface_supported = 1'b1;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    void'($urandom(74));
    // Reset values, write-only reads and an unmapped place
    for (int k = 0; k < 4; k++)
      bus_read(midx[k], 32'h0000_0000);
    bus_read(IDX_BUS_EVENT_IRQ_CLEAR, 32'h0000_00FF);
    bus_read(IDX_EP0_GENERAL_IRQ_CLEAR, 32'h0000_00FF);
    bus_read(32'hFFFF_FE1C, 32'h0000_0000);
    check_lines(3'b000);
    // Mask storage, fixed-zero bits and a write without byte enable
    for (int k = 0; k < 4; k++)
    begin
      d = 8'($urandom);
      bus_write(midx[k], d);
      bus_read(midx[k], {24'h00_0000, d & mbits[k]});
      bus_xfer(1'b0, midx[k], ~d, 4'h0);
      bus_read(midx[k], {24'h00_0000, d & mbits[k]});
      bus_write(midx[k], 8'h00);
    end
    // General line per source
    for (int i = 0; i < 7; i++)
    begin
      ep0_general_status <= 8'(1 << i);
      check_lines(3'b100);
      bus_write(IDX_EP0_GENERAL_IRQ_MASK, ~8'(1 << i));
      check_lines(3'b100);
      bus_write(IDX_EP0_GENERAL_IRQ_MASK, 8'(1 << i));
      check_lines(3'b000);
      bus_write(IDX_EP0_GENERAL_IRQ_MASK, 8'h00);
    end
    ep0_general_status <= 8'h00;
    bus_write(IDX_EP0_GENERAL_IRQ_MASK, 8'h7F);
    bus_event_irq_req <= 1'b1;
    check_lines(3'b100);
    bus_event_irq_req <= 1'b0;
    bus_write(IDX_EP0_GENERAL_IRQ_MASK, 8'h00);
    // Endpoint line per source: unmasked, masked, unsupported
    for (int b = 0; b < 16; b++)
    begin
      {bulk_out_status, bulk_in_intr_ep_status} <= 16'(1 << b);
      check_lines({1'b0, (b >= 8) | BULK_IN_MASK_BITS[b % 8], 1'b0});
      bus_write(midx[1 + b / 8], 8'(1 << (b % 8)));
      check_lines(3'b000);
      bus_write(midx[1 + b / 8], 8'h00);
      sup_v <= 6'h3F & ~6'(1 << sup_idx(b));
      check_lines(3'b000);
      sup_v <= 6'h3F;
    end
    // All endpoint sources at once: full masks, unmasked, then no support
    {bulk_out_status, bulk_in_intr_ep_status} <= 16'hFFFF;
    bus_write(IDX_BULK_IN_INTR_EP_IRQ_MASK, 8'hFF);
    bus_write(IDX_BULK_OUT_IRQ_MASK, 8'hFF);
    check_lines(3'b000);
    bus_write(IDX_BULK_IN_INTR_EP_IRQ_MASK, 8'h00);
    bus_write(IDX_BULK_OUT_IRQ_MASK, 8'h00);
    check_lines(3'b010);
    sup_v <= 6'h00;
    check_lines(3'b000);
    sup_v <= 6'h3F;
    {bulk_out_status, bulk_in_intr_ep_status} <= 16'h0000;
    // Set-interface line
    set_interface_status <= 8'hDF;
    check_lines(3'b000);
    set_interface_status <= 8'h20;
    check_lines(3'b001);
    bus_write(IDX_SET_INTERFACE_IRQ_MASK, 8'h20);
    check_lines(3'b000);
    bus_write(IDX_SET_INTERFACE_IRQ_MASK, 8'hDF);
    check_lines(3'b001);
    set_interface_supported <= 1'b0;
    check_lines(3'b000);
    set_interface_supported <= 1'b1;
    set_interface_status <= 8'h00;
    // Clear registers with sources still pending
    ep0_general_status <= 8'h7F;
    for (int k = 0; k < 10; k++)
    begin
      d  = (k < 2) ? 8'hFF : (k < 4) ? 8'h00 : 8'($urandom);
      ca = (k % 2 == 0) ? IDX_BUS_EVENT_IRQ_CLEAR : IDX_EP0_GENERAL_IRQ_CLEAR;
      ex = (k % 2 == 0) ? {~d & ~BUS_EVENT_CLR_FIXED, 8'h00}
                        : {8'h00, ~d & ~EP0_GENERAL_CLR_FIXED};
      if (ex != 16'h0000)
        pulse_q.push_back(ex);
      bus_write(ca, d);
      bus_read(ca, 32'h0000_00FF);
    end
    repeat (4) @(posedge core_clk);
    chk("reads left", 32'h0000_0000, 32'(rd_q.size()));
    chk("pulses left", 32'h0000_0000, 32'(pulse_q.size()));
    tally_and_finish();
  end
endmodule
`default_nettype wire
